// ### include/mssel_consts.vh
`ifndef MSSEL_CONSTS_VH
`define MSSEL_CONSTS_VH
// Register byte offsets
`define MSSEL_REG_CTRL      8'h00
`define MSSEL_REG_STATUS    8'h04
`define MSSEL_REG_OFFSET    8'h08
`define MSSEL_REG_ANALOG    8'h0C
`define MSSEL_REG_SET0      8'h10
`define MSSEL_SET_STRIDE    8'h04
`define MSSEL_REG_RAMP0     8'h20
// Control fields
`define MSSEL_CTRL_EXT_EN   0
// Data set fields
`define MSSEL_SPEED_W       12
`define MSSEL_RAMP_W        8
`define MSSEL_DEC_LSB       16
// Timing
`define MSSEL_CLK_MHZ       250
`define MSSEL_TICK_US       100
`define MSSEL_TICK_CYC      (`MSSEL_CLK_MHZ * `MSSEL_TICK_US)
`define MSSEL_BRAKE_MS      400
`define MSSEL_BRAKE_TICKS   (`MSSEL_BRAKE_MS * 1000 / `MSSEL_TICK_US)
`define MSSEL_SPEED_MAX     12'hFFF
`define MSSEL_OFS_MAX       12'd800
// Bus responses
`define MSSEL_RESP_OKAY     2'b00
`define MSSEL_RESP_SLVERR   2'b10
`endif

// ### logic/mssel_ramp.v
`default_nettype none
`include "mssel_consts.vh"
// Linear ramp: steps speed by one unit per enable until it meets target
module mssel_ramp (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_rst,
    // Control
    input  wire        i_step,
    input  wire        i_zero,
    input  wire [11:0] i_target,
    // Speed
    output reg  [11:0] o_speed
);
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_speed <= 12'h000;
        end else if (i_zero) begin
            o_speed <= 12'h000;
        end else if (i_step) begin
            if (o_speed < i_target) begin
                o_speed <= o_speed + 12'h001;
            end else if (o_speed > i_target) begin
                o_speed <= o_speed - 12'h001;
            end
        end
    end
endmodule // mssel_ramp
`default_nettype wire

// ### logic/mssel_top.v
`default_nettype none
`include "mssel_consts.vh"
module mssel_top (
    // Clock and reset
    input  wire        I_CLK,
    input  wire        I_RST,
    // Discrete command inputs (asynchronous pins)
    input  wire        I_FORWARD_RUN_CMD,
    input  wire        I_REVERSE_RUN_CMD,
    input  wire        I_SET_SELECT_LO,
    input  wire        I_SET_SELECT_HI,
    // AXI4-Lite write address
    input  wire [7:0]  I_AWADDR,
    input  wire        I_AWVALID,
    output wire        O_AWREADY,
    // AXI4-Lite write data
    input  wire [31:0] I_WDATA,
    input  wire [3:0]  I_WSTRB,
    input  wire        I_WVALID,
    output wire        O_WREADY,
    // AXI4-Lite write response
    output reg  [1:0]  O_BRESP,
    output reg         O_BVALID,
    input  wire        I_BREADY,
    // AXI4-Lite read address
    input  wire [7:0]  I_ARADDR,
    input  wire        I_ARVALID,
    output wire        O_ARREADY,
    // AXI4-Lite read data
    output reg  [31:0] O_RDATA,
    output reg  [1:0]  O_RRESP,
    output reg         O_RVALID,
    input  wire        I_RREADY,
    // Motor drive
    output reg  [11:0] O_SPEED,
    output reg         O_DIR_REVERSE,
    output reg         O_DRIVE,
    output reg         O_BRAKE,
    output reg  [1:0]  O_ACTIVE_SET
);
    localparam S_IDLE  = 3'b001;
    localparam S_RUN   = 3'b010;
    localparam S_BRAKE = 3'b100;

    // Two-flop synchronisers for the pins
    reg  [3:0] pin_meta;
    reg  [3:0] pin_sync;
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
        end else begin
            pin_meta <= {I_SET_SELECT_HI, I_SET_SELECT_LO,
                         I_REVERSE_RUN_CMD, I_FORWARD_RUN_CMD};
            pin_sync <= pin_meta;
        end
    end
    wire       forward_run_cmd = pin_sync[0];
    wire       reverse_run_cmd = pin_sync[1];
    wire [1:0] sel = pin_sync[3:2];

    // Registers
    reg        ext_en;
    reg [11:0] ofs;
    reg [11:0] analog;
    reg [11:0] set_speed [0:3];
    reg [31:0] set_ramp  [0:3];

    // Register index decode, shared by read and write paths
    function [3:0] reg_idx;
        input [7:0] addr;
        begin
            reg_idx = addr[5:2];
        end
    endfunction

    // Write channel: both taken together once both are offered and no response is pending
    wire wr_go = I_AWVALID && I_WVALID && !O_BVALID;
    assign O_AWREADY = wr_go;
    assign O_WREADY  = wr_go;
    wire [3:0] wi = reg_idx(I_AWADDR);
    wire wr_hit = (I_AWADDR[7:6] == 2'b00) && (wi <= 4'd11);
    integer k;
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_BVALID <= 1'b0;
            O_BRESP  <= `MSSEL_RESP_OKAY;
            ext_en   <= 1'b0;
            ofs      <= 12'h000;
            analog   <= 12'h000;
            for (k = 0; k < 4; k = k + 1) begin
                set_speed[k] <= 12'h000;
                set_ramp[k]  <= 32'h0000_0000;
            end
        end else begin
            if (O_BVALID && I_BREADY) begin
                O_BVALID <= 1'b0;
            end
            if (wr_go) begin
                O_BVALID <= 1'b1;
                O_BRESP  <= wr_hit ? `MSSEL_RESP_OKAY : `MSSEL_RESP_SLVERR;
                if (wr_hit && I_WSTRB[0]) begin
                    case (I_AWADDR & 8'hFC)
                        `MSSEL_REG_CTRL:
                            ext_en <= I_WDATA[`MSSEL_CTRL_EXT_EN];
                        `MSSEL_REG_OFFSET:
                            ofs <= (I_WDATA[11:0] > `MSSEL_OFS_MAX) ?
                                   `MSSEL_OFS_MAX : I_WDATA[11:0];
                        `MSSEL_REG_ANALOG:
                            analog <= I_WDATA[11:0];
                        default: begin
                            if (wi >= 4'd4 && wi <= 4'd7) begin
                                set_speed[wi[1:0]] <= I_WDATA[11:0];
                            end else if (wi >= 4'd8) begin
                                set_ramp[wi[1:0]] <= I_WDATA;
                            end
                        end
                    endcase
                end
            end
        end
    end

    // Read channel
    reg  [2:0] state;
    wire [3:0] ri = reg_idx(I_ARADDR);
    wire rd_hit = (I_ARADDR[7:6] == 2'b00) && (ri <= 4'd11);
    assign O_ARREADY = !O_RVALID;
    reg [31:0] rd_val;
    always @* begin
        rd_val = 32'h0000_0000;
        case (I_ARADDR & 8'hFC)
            `MSSEL_REG_CTRL:   rd_val = {31'h0, ext_en};
            `MSSEL_REG_STATUS: rd_val = {O_SPEED, 12'h000, O_ACTIVE_SET,
                                         O_BRAKE, O_DRIVE, O_DIR_REVERSE,
                                         state};
            `MSSEL_REG_OFFSET: rd_val = {20'h0, ofs};
            `MSSEL_REG_ANALOG: rd_val = {20'h0, analog};
            default: begin
                if (ri >= 4'd4 && ri <= 4'd7) begin
                    rd_val = {20'h0, set_speed[ri[1:0]]};
                end else if (ri >= 4'd8 && ri <= 4'd11) begin
                    rd_val = set_ramp[ri[1:0]];
                end
            end
        endcase
    end
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_RVALID <= 1'b0;
            O_RDATA  <= 32'h0000_0000;
            O_RRESP  <= `MSSEL_RESP_OKAY;
        end else if (O_RVALID) begin
            if (I_RREADY) begin
                O_RVALID <= 1'b0;
            end
        end else if (I_ARVALID) begin
            O_RVALID <= 1'b1;
            O_RDATA  <= rd_hit ? rd_val : 32'h0000_0000;
            O_RRESP  <= rd_hit ? `MSSEL_RESP_OKAY : `MSSEL_RESP_SLVERR;
        end
    end

    // Target speed of the selected set
    wire [12:0] ext_sum = {1'b0, analog} + {1'b0, ofs};
    wire [11:0] ext_spd = ext_sum[12] ? `MSSEL_SPEED_MAX : ext_sum[11:0];
    wire [11:0] target  = (sel == 2'b00 && ext_en) ? ext_spd
                                                   : set_speed[sel];
    wire [7:0]  acc_t   = set_ramp[sel][`MSSEL_RAMP_W-1:0];
    wire [7:0]  dec_t   = set_ramp[sel][`MSSEL_DEC_LSB+`MSSEL_RAMP_W-1:
                                        `MSSEL_DEC_LSB];

    // Time base tick
    reg [15:0] tick_cnt;
    // Widened compare keeps the 32-bit constant intact
    wire       tick = ({16'h0000, tick_cnt} == `MSSEL_TICK_CYC - 1);
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            tick_cnt <= 16'h0000;
        end else begin
            tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
        end
    end

    // Ramp stepping: one step every ramp_time+1 ticks per unit of speed
    // Trade-off: step spacing is fixed per set, so a full-scale change
    // takes the ramp time scaled by the distance, linear in time.
    wire [11:0] speed_now;
    reg  [11:0] ramp_tgt;
    wire        rising = (speed_now < ramp_tgt);
    wire [7:0]  step_t  = rising ? acc_t : dec_t;
    reg  [7:0]  step_cnt;
    wire        step = tick && (step_cnt >= step_t);
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            step_cnt <= 8'h00;
        end else if (step) begin
            step_cnt <= 8'h00;
        end else if (tick) begin
            step_cnt <= step_cnt + 8'h01;
        end
    end

    // Run control
    reg  [12:0] brake_cnt;
    wire        brake_done = ({19'h0_0000, brake_cnt} == `MSSEL_BRAKE_TICKS);
    reg         start_rev;
    wire        both  = forward_run_cmd && reverse_run_cmd;
    wire        one   = forward_run_cmd ^ reverse_run_cmd;
    wire        zero_now;
    reg  [2:0]  next_state;
    always @* begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (both && speed_now != 12'h000) begin
                    next_state = S_BRAKE;
                end else if (one) begin
                    next_state = S_RUN;
                end
            end
            S_RUN: begin
                if (both) begin
                    next_state = S_BRAKE;
                end else if (start_rev ? !reverse_run_cmd : !forward_run_cmd) begin
                    next_state = S_IDLE;
                end
            end
            S_BRAKE: begin
                if (one) begin
                    next_state = S_RUN;
                end else if (brake_done) begin
                    next_state = S_IDLE;
                end
            end
            default: next_state = S_IDLE;
        endcase
    end
    assign zero_now = (next_state == S_BRAKE);

    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            state     <= S_IDLE;
            brake_cnt <= 13'h0000;
            start_rev <= 1'b0;
        end else begin
            state <= next_state;
            if (state != S_BRAKE) begin
                brake_cnt <= 13'h0000;
            end else if (tick) begin
                brake_cnt <= brake_cnt + 13'h0001;
            end
            if (next_state == S_RUN && state != S_RUN) begin
                start_rev <= reverse_run_cmd;
            end
        end
    end

    // Ramp target: selected speed while running, zero otherwise
    always @* begin
        ramp_tgt = (state == S_RUN) ? target : 12'h000;
    end

    mssel_ramp u_ramp (
        .i_clk    (I_CLK),
        .i_rst    (I_RST),
        .i_step   (step),
        .i_zero   (zero_now),
        .i_target (ramp_tgt),
        .o_speed  (speed_now)
    );

    // Registered drive outputs
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_SPEED       <= 12'h000;
            O_DIR_REVERSE <= 1'b0;
            O_DRIVE       <= 1'b0;
            O_BRAKE       <= 1'b0;
            O_ACTIVE_SET  <= 2'b00;
        end else begin
            O_SPEED       <= speed_now;
            O_DIR_REVERSE <= start_rev;
            O_DRIVE       <= (state == S_RUN) || (speed_now != 12'h000);
            O_BRAKE       <= (state == S_BRAKE);
            O_ACTIVE_SET  <= sel;
        end
    end
endmodule // mssel_top
`default_nettype wire

// ### sim/mssel_switch_model.sv
`default_nettype none
// External switch bank: {hi select, lo select, reverse, forward}
module mssel_switch_model #(
    parameter int HOLD = 16
) (
    // Clock
    input  wire logic       i_clk,
    // Requested and applied levels
    input  wire logic [3:0] i_req,
    output var  logic [3:0] o_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial o_pins = 4'h0;
    // Minimum hold is shortened to HOLD+1 cycles so the run stays short
    always @(posedge i_clk) begin
        if (cnt != 0) begin
            cnt <= cnt - 1;
        end else if (i_req !== o_pins) begin
            o_pins <= i_req;
            cnt    <= HOLD;
        end
    end
endmodule // mssel_switch_model
`default_nettype wire

// ### sim/mssel_checker.sv
`default_nettype none
module mssel_checker (
    // Clock and reset
    input wire logic        I_CLK,
    input wire logic        I_RST,
    // Pins and bus handshakes
    input wire logic        I_FORWARD_RUN_CMD,
    input wire logic        I_REVERSE_RUN_CMD,
    input wire logic        I_SET_SELECT_LO,
    input wire logic        I_SET_SELECT_HI,
    input wire logic        I_AWVALID,
    input wire logic        I_WVALID,
    input wire logic        I_ARVALID,
    input wire logic        O_BVALID,
    input wire logic        O_RVALID,
    // Motor drive
    input wire logic [11:0] O_SPEED,
    input wire logic        O_DIR_REVERSE,
    input wire logic        O_DRIVE,
    input wire logic        O_BRAKE,
    input wire logic [1:0]  O_ACTIVE_SET
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BRAKE_CYC = 100_000_000;
    // The first brake tick may come up to one tick period after entry
    localparam int TICK_CYC  = 25_000;
    int  brake_cyc;
    wire forward_run_cmd = I_FORWARD_RUN_CMD;
    wire reverse_run_cmd = I_REVERSE_RUN_CMD;
    wire [1:0] sel = {I_SET_SELECT_HI, I_SET_SELECT_LO};
    always @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            brake_cyc <= 0;
        end else begin
            brake_cyc <= O_BRAKE ? brake_cyc + 1 : 0;
        end
    end
    default clocking @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);
    // Margins cover the two-flop pin synchroniser
    AST_SET: assert property ((O_DRIVE && $stable(sel)) [*6] |->
        O_ACTIVE_SET == sel) else $error("active set wrong");
    AST_BOTH: assert property ((forward_run_cmd && reverse_run_cmd) [*5] |->
        O_SPEED == 12'h000) else $error("no instant stop");
    AST_BRK_ZERO: assert property (O_BRAKE |->
        O_SPEED == 12'h000) else $error("speed during brake");
    AST_BRK_LEN: assert property ($fell(O_BRAKE) |->
        (forward_run_cmd ^ reverse_run_cmd) || brake_cyc >= BRAKE_CYC - TICK_CYC)
        else $error("brake short");
    AST_RESUME: assert property (O_BRAKE && (forward_run_cmd ^ reverse_run_cmd) |->
        ##[1:5] (!O_BRAKE && O_DRIVE)) else $error("no resume");
    AST_DIR: assert property ($rose(O_DRIVE) |->
        ##[0:1] (O_DIR_REVERSE == reverse_run_cmd)) else $error("direction wrong");
    AST_STOP: assert property ((!forward_run_cmd && !reverse_run_cmd) [*6] |->
        O_SPEED <= $past(O_SPEED)) else $error("speed rose when off");
    AST_RAMP: assert property ($changed(O_SPEED) && O_SPEED != 0 |->
        (O_SPEED - $past(O_SPEED) == 12'h001) ||
        ($past(O_SPEED) - O_SPEED == 12'h001)) else $error("ramp jump");
    AST_BANS: assert property (I_AWVALID && I_WVALID && !O_BVALID |=>
        O_BVALID) else $error("late write answer");
    AST_RANS: assert property (I_ARVALID && !O_RVALID |=>
        O_RVALID) else $error("late read answer");
endmodule // mssel_checker
bind mssel_top mssel_checker i_chk (.I_CLK(I_CLK), .I_RST(I_RST),
    .I_FORWARD_RUN_CMD(I_FORWARD_RUN_CMD),
    .I_REVERSE_RUN_CMD(I_REVERSE_RUN_CMD),
    .I_SET_SELECT_LO(I_SET_SELECT_LO), .I_SET_SELECT_HI(I_SET_SELECT_HI),
    .I_AWVALID(I_AWVALID), .I_WVALID(I_WVALID), .I_ARVALID(I_ARVALID),
    .O_BVALID(O_BVALID), .O_RVALID(O_RVALID), .O_SPEED(O_SPEED),
    .O_DIR_REVERSE(O_DIR_REVERSE), .O_DRIVE(O_DRIVE), .O_BRAKE(O_BRAKE),
    .O_ACTIVE_SET(O_ACTIVE_SET));
`default_nettype wire

// ### sim/test_multi_speed_run_selector.sv
`default_nettype none
`include "mssel_consts.vh"
module test_multi_speed_run_selector;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0;
    logic [3:0]  req = 4'h0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, r;
    logic [31:0] seed = 32'h3f8d_f8e6;
    wire  logic [3:0]  pins;
    wire  logic        awready, wready, bvalid, arready, rvalid;
    wire  logic        rev_dir, drive, brake;
    wire  logic [1:0]  bresp, rresp, act_set;
    wire  logic [31:0] rdata;
    wire  logic [11:0] speed;
    logic [33:0] exp_q[$];
    int          n_mismatch = 0, comparisons = 0, cyc = 0, i;
    always #2 clk = ~clk;
    mssel_switch_model #(.HOLD(16)) i_sw (.i_clk(clk), .i_req(req),
        .o_pins(pins));
    mssel_top i_dut (.I_CLK(clk), .I_RST(rst),
        .I_FORWARD_RUN_CMD(pins[0]), .I_REVERSE_RUN_CMD(pins[1]),
        .I_SET_SELECT_LO(pins[2]), .I_SET_SELECT_HI(pins[3]),
        .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
        .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid),
        .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
        .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
        .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
        .O_RVALID(rvalid), .I_RREADY(rready), .O_SPEED(speed),
        .O_DIR_REVERSE(rev_dir), .O_DRIVE(drive), .O_BRAKE(brake),
        .O_ACTIVE_SET(act_set));
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(negedge clk); while (!(awready && wready));
        @(posedge clk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(negedge clk); while (!bvalid);
        chk(bresp, `MSSEL_RESP_OKAY);
        @(posedge clk);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk); while (!arready);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (!rvalid);
        @(posedge clk);
        rready <= 1'b0;
    endtask
    // Pins are {hi select, lo select, reverse, forward}
    task automatic go(input logic [3:0] p, input int n);
        @(posedge clk);
        req <= p;
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Read results are judged at the falling edge, clear of update races
    always @(negedge clk) begin
        if (rvalid && rready) begin
            chk({rresp, rdata}, exp_q.pop_front());
        end
        cyc++;
        if (cyc == 100_000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (7) @(posedge clk);
        @(negedge clk);
        chk({drive, brake, speed, act_set}, 34'h0);
        @(posedge clk);
        rst <= 1'b0;
        $display("reset test done");
        wr(`MSSEL_REG_SET0 + `MSSEL_SET_STRIDE, 32'h0000_0123);
        wr(`MSSEL_REG_RAMP0 + `MSSEL_SET_STRIDE, 32'h0000_0000);
        wr(`MSSEL_REG_SET0, 32'h0000_0000);
        r = $random(seed) & 32'h0000_0FFF;
        wr(`MSSEL_REG_SET0 + 8'h08, r);
        wr(`MSSEL_REG_OFFSET, 32'h0000_03FF);
        rd(`MSSEL_REG_SET0 + 8'h04, {`MSSEL_RESP_OKAY, 32'h0000_0123});
        rd(`MSSEL_REG_SET0 + 8'h08, {`MSSEL_RESP_OKAY, r});
        rd(`MSSEL_REG_OFFSET, {2'b00, 20'h0_0000, `MSSEL_OFS_MAX});
        rd(8'h40, {`MSSEL_RESP_SLVERR, 32'h0000_0000});
        $display("register test done");
        go(4'b0101, 40);
        chk({drive, rev_dir}, 2'b10);
        for (i = 0; i < 4; i++) begin
            go({i[1:0], 2'b01}, 40);
            chk(act_set, i[1:0]);
        end
        go(4'b0101, 26000);
        chk(speed != 12'h000, 1'b1);
        $display("run test done");
        go(4'b0111, 40);
        chk({speed, brake}, {12'h000, 1'b1});
        go(4'b0110, 40);
        chk({brake, drive, rev_dir}, 3'b011);
        go(4'b0100, 30000);
        chk(drive, 1'b0);
        $display("brake test done");
        wr(`MSSEL_REG_CTRL, 32'h0000_0001);
        wr(`MSSEL_REG_ANALOG, 32'h0000_0000);
        go(4'b0001, 30000);
        chk(speed != 12'h000, 1'b1);
        $display("analog test done");
        tally_and_finish();
    end
endmodule // test_multi_speed_run_selector
`default_nettype wire
